// ### amsfc_bench.sv
`timescale 1ns/1ps
module amsfc_bench;
  logic sys_clk = 1'h0, rst = 1'h1, power_up = 1'h0, clock_role_select = 1'h0;
  logic short_detect = 1'h0, over_temp = 1'h0, bias_ready = 1'h0, mute = 1'h0;
  logic retry = 1'h0, short_on = 1'h0, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic silence, sync_in, sync_drv, sync_out, sync_oe, fault, irq, switch_enable;
  logic switch_clk, low_current, wb_ack_o, wb_err_o, e;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hF;
  int err_total = 0, checked = 0, n;
  always #5 sys_clk = ~sys_clk;
  assign sync_in = sync_oe ? sync_out : sync_drv;
  // a shorted output is only seen while it is driven
  always @(posedge sys_clk) short_detect <= short_on && switch_enable === 1'h1;
  amsfc_core #(.START_CYC(20), .OSC_HALF(4)) dut (.sys_clk(sys_clk), .rst(rst),
    .silence(silence), .power_up(power_up), .clock_role_select(clock_role_select),
    .short_detect(short_detect), .over_temp(over_temp), .bias_ready(bias_ready),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .fault(fault),
    .switch_enable(switch_enable), .switch_clk(switch_clk), .low_current(low_current),
    .irq(irq), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
  amsfc_host host (.sys_clk, .rst, .fault, .mute_req(mute), .retry_en(retry),
    .lead_en(!clock_role_select), .silence, .sync_drv);
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask : ck
  task automatic ck1(input logic g, input logic x);
    ck({31'h0, g}, {31'h0, x});
  endtask : ck1
  task automatic end_of_test(input int hung);
    err_total += hung;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic tk(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'h3};
    for (i = 0; i < 50 && wb_ack_o !== 1'h1 && wb_err_o !== 1'h1; i++)
      @(posedge sys_clk);
    if (i == 50)
      end_of_test(1);
    {q, e} = {wb_dat_o, wb_err_o};
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic wait_en;
    for (n = 0; switch_enable !== 1'h1; n++)
    begin
      @(posedge sys_clk);
      if (n > 300)
        end_of_test(1);
    end
  endtask : wait_en
  task automatic rises(input int k, input int cyc);
    logic p;
    logic v;
    {n, p} = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk);
      v = (k == 0) ? sync_out : (k == 1) ? switch_clk : fault;
      n += (v === 1'h1 && p !== 1'h1);
      p = v;
    end
  endtask : rises
  task automatic t_start;
    ck1(low_current, 1'h1);
    power_up <= 1'h1;
    tk(10);
    ck1(switch_enable, 1'h0);
    ck1(low_current, 1'h0);
    bias_ready <= 1'h1;
    wait_en();
    ck1(n >= 20, 1'h1);
    ck1(low_current, 1'h0);
    wb(8'h04, 1'h0, 32'h0);
    ck(q, 32'h1A);
    wb(8'h00, 1'h0, 32'h0);
    ck(q, 32'h0);
    wb(8'h0C, 1'h0, 32'h0);
    ck(q, 32'h0);
    wb(8'h10, 1'h0, 32'h0);
    ck1(e, 1'h1);
    $display("start and registers done");
  endtask : t_start
  task automatic t_short;
    short_on <= 1'h1;
    tk(2);
    short_on <= 1'h0;
    tk(4);
    ck1(fault, 1'h1);
    ck1(switch_enable, 1'h0);
    ck1(irq, 1'h0);
    wb(8'h0C, 1'h1, 32'h1);
    tk(1);
    ck1(irq, 1'h1);
    wb(8'h08, 1'h1, 32'h1);
    tk(1);
    ck1(irq, 1'h0);
    ck1(fault, 1'h1);
    mute <= 1'h1;
    tk(4);
    ck1(switch_enable, 1'h0);
    mute <= 1'h0;
    tk(4);
    ck1(fault, 1'h0);
    wait_en();
    $display("short done");
  endtask : t_short
  task automatic t_retry;
    {short_on, retry} <= 2'h3;
    rises(2, 80);
    ck1(n >= 3, 1'h1);
    short_on <= 1'h0;
    wait_en();
    ck1(fault, 1'h0);
    mute <= 1'h1;
    tk(4);
    ck1(switch_enable, 1'h0);
    {mute, retry} <= 2'h0;
    wait_en();
    $display("retry done");
  endtask : t_retry
  task automatic t_pdn;
    short_on <= 1'h1;
    tk(2);
    short_on <= 1'h0;
    tk(4);
    ck1(fault, 1'h1);
    power_up <= 1'h0;
    tk(4);
    ck1(switch_enable, 1'h0);
    ck1(low_current, 1'h1);
    ck1(fault, 1'h1);
    power_up <= 1'h1;
    wait_en();
    ck1(fault, 1'h0);
    ck1(n >= 20, 1'h1);
    $display("power-down done");
  endtask : t_pdn
  task automatic t_ctrl;
    wb(8'h00, 1'h1, 32'h1);
    tk(1);
    ck1(switch_enable, 1'h0);
    wb(8'h00, 1'h0, 32'h0);
    ck(q, 32'h1);
    wb(8'h00, 1'h1, 32'h2);
    wait_en();
    short_on <= 1'h1;
    rises(2, 30);
    ck1(n >= 3, 1'h1);
    short_on <= 1'h0;
    tk(4);
    wb(8'h00, 1'h1, 32'h0);
    wait_en();
    ck1(fault, 1'h0);
    $display("control register done");
  endtask : t_ctrl
  task automatic t_temp;
    over_temp <= 1'h1;
    tk(30);
    ck1(switch_enable, 1'h0);
    over_temp <= 1'h0;
    wait_en();
    ck1(n >= 20, 1'h1);
    ck1(irq, 1'h1);
    wb(8'h08, 1'h0, 32'h0);
    ck(q, 32'h7);
    wb(8'h08, 1'h1, 32'h7);
    wb(8'h08, 1'h0, 32'h0);
    ck(q, 32'h0);
    ck1(irq, 1'h0);
    $display("thermal done");
  endtask : t_temp
  task automatic t_role;
    clock_role_select <= 1'h1;
    tk(6);
    ck1(sync_oe, 1'h1);
    rises(0, 40);
    ck1(n >= 4, 1'h1);
    rises(1, 40);
    ck1(n >= 4, 1'h1);
    clock_role_select <= 1'h0;
    tk(6);
    ck1(sync_oe, 1'h0);
    rises(1, 1200);
    ck1(n >= 2 && n <= 4, 1'h1);
    $display("role done");
  endtask : t_role
  initial
  begin
    tk(5);
    rst <= 1'h0;
    tk(2);
    t_start();
    t_short();
    t_retry();
    t_pdn();
    t_ctrl();
    t_temp();
    t_role();
    end_of_test(0);
  end
endmodule : amsfc_bench

// ### amsfc_core.sv
// Behaviour
// - silence high stops output switching, silence low enables it.
// - detected output short disables output drive immediately.
// - short flag latches until power-down or silence toggles; re-triggers if persisting.
// - fault output high while short flag set, low once cleared.
// - role select high: internal oscillator drives sync pin push-pull.
// - role select low: sync pin is input, switching follows it.
// - over-temperature powers down outputs unlatched, resumes automatically when cooled.
// - power-down low silences outputs and enters low-current state.
// - after bias node ready, wait 16.4 ms before switching starts.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module amsfc_core #(
  parameter int START_CYC = amsfc_pkg::START_DELAY_CYC,
  parameter int OSC_HALF = amsfc_pkg::OSC_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic silence,
  input wire logic power_up,
  input wire logic clock_role_select,
  input wire logic short_detect,
  input wire logic over_temp,
  input wire logic bias_ready,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic fault,
  output logic switch_enable,
  output logic switch_clk,
  output logic low_current,
  output logic irq,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o
);
  amsfc_pkg::amsfc_ctl_t raw_w;
  amsfc_pkg::amsfc_ctl_t ctl_w;
  amsfc_pkg::amsfc_state_t state_q;
  amsfc_pkg::amsfc_state_t state_d;
  logic [amsfc_pkg::START_W-1:0] start_cnt_q;
  logic [amsfc_pkg::OSC_W-1:0] osc_cnt_q;
  logic osc_q;
  logic sync_prev_q;
  logic short_flag_q;
  logic silence_prev_q;
  logic pwr_prev_q;
  logic [1:0] ctrl_q;
  logic [amsfc_pkg::EV_W-1:0] stat_q;
  logic [amsfc_pkg::EV_W-1:0] mask_q;
  logic [amsfc_pkg::EV_W-1:0] ev_w;
  logic run_prev_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic eff_silence;
  logic toggle_clear;
  logic drive_ok;
  logic osc_wrap;
  logic run_w;
  logic req_w;
  logic hit_ctrl;
  logic hit_state;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;
  logic wr_low;
  logic [31:0] rd_mux;
  logic [amsfc_pkg::EV_W-1:0] stat_clr;

  // only the silence, power-up and role-select pins pass the synchroniser; register silence is already in this clock domain
  assign raw_w.silence = silence;
  assign raw_w.power_up = power_up;
  assign raw_w.clock_role_select = clock_role_select;

  amsfc_sync #(
    .W(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(raw_w),
    .dout(ctl_w)
  );

  // software silence and optional on-chip retry loop mirror the board-level OR
  assign eff_silence = ctl_w.silence | ctrl_q[amsfc_pkg::CTRL_SILENCE]
    | (ctrl_q[amsfc_pkg::CTRL_AUTO_RETRY] & short_flag_q);

  // a rising edge on either control clears the latched short
  assign toggle_clear = (eff_silence & ~silence_prev_q)
    | (ctl_w.power_up & ~pwr_prev_q);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      silence_prev_q <= 1'b0;
      pwr_prev_q <= 1'b0;
    end
    else
    begin
      silence_prev_q <= eff_silence;
      pwr_prev_q <= ctl_w.power_up;
    end
  end

  // short set wins over clear so a persisting short re-triggers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      short_flag_q <= 1'b0;
    else if (short_detect)
      short_flag_q <= 1'b1;
    else if (toggle_clear)
      short_flag_q <= 1'b0;
  end

  assign fault = short_flag_q;

  // start-up sequencer; thermal trip behaves as power-down without latching
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      amsfc_pkg::AMSFC_OFF:
        if (ctl_w.power_up && !over_temp)
          state_d = amsfc_pkg::AMSFC_BIAS;
      amsfc_pkg::AMSFC_BIAS:
        if (!ctl_w.power_up || over_temp)
          state_d = amsfc_pkg::AMSFC_OFF;
        else if (bias_ready)
          state_d = amsfc_pkg::AMSFC_WAIT;
      amsfc_pkg::AMSFC_WAIT:
        if (!ctl_w.power_up || over_temp)
          state_d = amsfc_pkg::AMSFC_OFF;
        else if (start_cnt_q == amsfc_pkg::START_W'(START_CYC - 1))
          state_d = amsfc_pkg::AMSFC_RUN;
      amsfc_pkg::AMSFC_RUN:
        if (!ctl_w.power_up || over_temp)
          state_d = amsfc_pkg::AMSFC_OFF;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= amsfc_pkg::AMSFC_OFF;
      start_cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      start_cnt_q <= (state_q == amsfc_pkg::AMSFC_WAIT) ? start_cnt_q + 1'b1 : '0;
    end
  end

  assign run_w = (state_q == amsfc_pkg::AMSFC_RUN);
  assign low_current = (state_q == amsfc_pkg::AMSFC_OFF) & ~ctl_w.power_up;
  // short_detect gates drive combinationally so the cutoff is immediate
  assign drive_ok = run_w & ~eff_silence & ~short_flag_q & ~short_detect
    & ~over_temp;
  assign switch_enable = drive_ok;

  // internal oscillator, about 250 kHz from the system clock
  assign osc_wrap = (osc_cnt_q == amsfc_pkg::OSC_W'(OSC_HALF - 1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      osc_cnt_q <= '0;
      osc_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      osc_cnt_q <= osc_wrap ? '0 : osc_cnt_q + 1'b1;
      if (osc_wrap)
        osc_q <= ~osc_q;
      sync_prev_q <= sync_in;
    end
  end

  assign sync_oe = ctl_w.clock_role_select;
  assign sync_out = osc_q;
  // follower locks switching to the incoming square wave; sync_in assumed synchronous
  assign switch_clk = drive_ok
    & (ctl_w.clock_role_select ? osc_q : sync_in);

  // interrupts: sticky, write one to clear, set wins
  assign ev_w[amsfc_pkg::EV_SHORT] = short_detect;
  assign ev_w[amsfc_pkg::EV_THERMAL] = over_temp;
  assign ev_w[amsfc_pkg::EV_RUN] = run_w & ~run_prev_q;

  // wishbone classic slave, one registered ack per request, a cycle after the strobe (err if unmapped)
  assign req_w = wb_cyc_i & wb_stb_i & ~ack_q;
  assign hit_ctrl = (wb_adr_i == amsfc_pkg::ADDR_CTRL);
  assign hit_state = (wb_adr_i == amsfc_pkg::ADDR_STATE);
  assign hit_stat = (wb_adr_i == amsfc_pkg::ADDR_IRQ_STAT);
  assign hit_mask = (wb_adr_i == amsfc_pkg::ADDR_IRQ_MASK);
  assign hit_any = hit_ctrl | hit_state | hit_stat | hit_mask;
  assign wr_low = req_w & wb_we_i & wb_sel_i[0] & hit_any;
  assign rd_mux = hit_ctrl ? {30'h0, ctrl_q}
    : hit_state ? {24'h0, ctl_w.clock_role_select, over_temp, short_flag_q,
                   switch_enable, state_q, ctl_w.power_up, eff_silence}
    : hit_stat ? {29'h0, stat_q}
    : hit_mask ? {29'h0, mask_q}
    : 32'h0;

  // write-one-to-clear mask; an event in the same cycle still sets its bit
  assign stat_clr = (wr_low && hit_stat) ? wb_dat_i[amsfc_pkg::EV_W-1:0] : '0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= req_w & hit_any;
      err_q <= req_w & ~hit_any;
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl_q <= amsfc_pkg::CTRL_RESET;
    else if (wr_low && hit_ctrl)
      ctrl_q <= wb_dat_i[1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mask_q <= amsfc_pkg::MASK_RESET;
    else if (wr_low && hit_mask)
      mask_q <= wb_dat_i[amsfc_pkg::EV_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stat_q <= '0;
      run_prev_q <= 1'b0;
    end
    else
    begin
      stat_q <= ev_w | (stat_q & ~stat_clr);
      run_prev_q <= run_w;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;
  assign irq = |(stat_q & mask_q);
endmodule : amsfc_core

// ### amsfc_host.sv
`timescale 1ns/1ps
module amsfc_host #(
  parameter int HALF = 200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fault,
  input wire logic mute_req,
  input wire logic retry_en,
  input wire logic lead_en,
  output logic silence,
  output logic sync_drv
);
  int cnt_q;
  // or gate keeps host muting and fault retry on one pin
  assign silence = mute_req | (retry_en & fault);
  // 250 kHz square; stands still while the amplifier leads
  always_ff @(posedge sys_clk)
  begin
    cnt_q <= (rst || !lead_en || cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    if (rst || !lead_en)
      sync_drv <= 1'h0;
    else if (cnt_q == HALF - 1)
      sync_drv <= ~sync_drv;
  end
endmodule : amsfc_host

// ### amsfc_pkg.sv
package amsfc_pkg;
  localparam int CLK_HZ = 100_000_000;
  // power-up delay after the bias node is ready
  localparam int START_DELAY_US_X10 = 164000;
  localparam int START_DELAY_CYC = (CLK_HZ / 1_000_000) * START_DELAY_US_X10 / 10;
  localparam int START_W = 21;
  // internal oscillator divider half period, about 250 kHz
  localparam int OSC_HALF_CYC = 200;
  localparam int OSC_W = 10;
  localparam int SYNC_STAGES = 2;

  // wishbone register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // ctrl fields
  localparam int CTRL_SILENCE = 0;
  localparam int CTRL_AUTO_RETRY = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // irq/status fields
  localparam int EV_SHORT = 0;
  localparam int EV_THERMAL = 1;
  localparam int EV_RUN = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] MASK_RESET = 3'h0;

  typedef enum logic [1:0]
  {
    AMSFC_OFF = 2'b00,
    AMSFC_BIAS = 2'b01,
    AMSFC_WAIT = 2'b11,
    AMSFC_RUN = 2'b10
  } amsfc_state_t;

  typedef struct packed
  {
    logic silence;
    logic power_up;
    logic clock_role_select;
  } amsfc_ctl_t;
endpackage : amsfc_pkg

// ### amsfc_properties.sv
`timescale 1ns/1ps
module amsfc_chk #(
  parameter int START_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic silence,
  input wire logic power_up,
  input wire logic clock_role_select,
  input wire logic short_detect,
  input wire logic over_temp,
  input wire logic bias_ready,
  input wire logic fault,
  input wire logic low_current,
  input wire logic sync_oe,
  input wire logic switch_enable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // three high samples: long enough to pass both sync stages
  sequence s_sil_rise; !silence ##1 silence [*3]; endsequence
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  property p_short; short_detect |=> fault; endproperty
  a_short: assert property (p_short) else $error("short not latched");
  property p_off; fault |-> !switch_enable; endproperty
  a_off: assert property (p_off) else $error("drive on with fault");
  property p_cut; short_detect |-> !switch_enable; endproperty
  a_cut: assert property (p_cut) else $error("drive on during short");
  property p_pdn; !power_up [*4] |-> !switch_enable && low_current; endproperty
  a_pdn: assert property (p_pdn) else $error("drive on in power-down");
  property p_clear; (!short_detect throughout s_sil_rise) |=> !fault; endproperty
  a_clear: assert property (p_clear) else $error("fault kept");
  property p_sil; silence [*3] |-> !switch_enable; endproperty
  a_sil: assert property (p_sil) else $error("drive on in silence");
  property p_temp; over_temp [*4] |-> !switch_enable; endproperty
  a_temp: assert property (p_temp) else $error("drive on when hot");
  property p_lead; clock_role_select [*4] |-> sync_oe; endproperty
  a_lead: assert property (p_lead) else $error("sync pin not driven");
  property p_follow; !clock_role_select [*4] |-> !sync_oe; endproperty
  a_follow: assert property (p_follow) else $error("sync pin driven");
  property p_start; $rose(switch_enable) |-> $past(bias_ready, START_CYC); endproperty
  a_start: assert property (p_start) else $error("start too early");
  property p_ack; s_req |=> wb_ack_o || wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("bus not answered");
endmodule : amsfc_chk
bind amsfc_core amsfc_chk #(.START_CYC(START_CYC)) u_chk (.sys_clk(sys_clk), .rst(rst),
  .silence(silence), .power_up(power_up), .clock_role_select(clock_role_select),
  .short_detect(short_detect), .over_temp(over_temp), .bias_ready(bias_ready), .fault(fault),
  .low_current(low_current), .sync_oe(sync_oe), .switch_enable(switch_enable),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

// ### amsfc_sync.sv
`timescale 1ns/1ps
module amsfc_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      hold_q <= '0;
    end
    else
    begin
      meta_q <= din;
      hold_q <= meta_q;
    end
  end

  assign dout = hold_q;
endmodule : amsfc_sync
